// [dv/isf_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------
// Far-side bus device
// ----------
module isf_bus_model (
	output logic scl_out,
	output logic sda_out
);
	// Both lines rest at the pull-up level; the clock stands still between frames.
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// One bit slot of 200 ns, data changed only while the clock is low.
	// Started on a block clock edge, every change lands 5 ns after an edge,
	// so the sampling flops never race the model.
	task automatic slot(input logic v);
		#5 scl_out = 1'b0;
		#25 sda_out = v;
		#75 scl_out = 1'b1;
		#95;
	endtask : slot
	// Eight data bits, then the slave's answer; the closing fall ends the
	// acknowledge slot and the released data line floats back high.
	task automatic xfer(input logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--) slot(d[i]);
		slot(ack);
		#5 scl_out = 1'b0;
		#25 sda_out = 1'b1;
	endtask : xfer
	// Data rises while the clock is high, which ends the frame.
	task automatic stop();
		#5 scl_out = 1'b0;
		#25 sda_out = 1'b0;
		#75 scl_out = 1'b1;
		#100 sda_out = 1'b1;
	endtask : stop
endmodule : isf_bus_model
`default_nettype wire

// [dv/isf_status_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------
// Port checks
// ----------
module isf_status_properties
	import isf_pkg::*;
(
	input wire logic              clk_in,
	input wire logic              sys_rst_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [31:0]       wdata_in,
	input wire logic              wr_in,
	input wire logic              rd_in,
	input wire logic [31:0]       rdata_out,
	input wire logic              busy_in,
	input wire logic              module_on_out,
	input wire logic              tx_load_out,
	input wire logic [7:0]        tx_data_out,
	input wire logic              irq_out
);
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
		else $error("read data outside its slot");
	a_zero_bits: assert property ($past(rd_in) && $past(addr_in) == OFS_STATUS
		|-> (rdata_out & 32'hffff_381f) == 32'h0) else $error("unused status bits set");
	a_reset_quiet: assert property ($fell(sys_rst_in) |-> !irq_out && !tx_load_out)
		else $error("outputs live after reset");
	a_txload_busy: assert property (wr_in && addr_in == OFS_TXBUF && busy_in |=> !tx_load_out)
		else $error("byte accepted while busy");
	a_txload_cause: assert property (tx_load_out |-> $past(wr_in) && $past(addr_in) == OFS_TXBUF
		&& tx_data_out == $past(wdata_in[7:0])) else $error("load without matching write");
	a_txload_off: assert property (wr_in && addr_in == OFS_TXBUF && !module_on_out |=> !tx_load_out)
		else $error("byte accepted while off");
	a_txdata_hold: assert property (!tx_load_out && $stable(module_on_out) |-> $stable(tx_data_out))
		else $error("transmit byte moved without load");
	a_on_write: assert property (wr_in && addr_in == OFS_CTRL
		|=> module_on_out == $past(wdata_in[CTRL_ON_BIT])) else $error("on bit not written");
	a_irq_mask: assert property (wr_in && addr_in == OFS_EVT_EN && wdata_in[5:0] == 6'h0
		##1 !(wr_in && addr_in == OFS_EVT_EN) |=> !irq_out) else $error("masked interrupt raised");
endmodule : isf_status_properties
bind isf_status isf_status_properties u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.busy_in(busy_in), .module_on_out(module_on_out), .tx_load_out(tx_load_out),
	.tx_data_out(tx_data_out), .irq_out(irq_out));
`default_nettype wire

// [dv/tb_i2c_status_flags.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------
// Status flag bench
// ----------
module tb_i2c_status_flags
	import isf_pkg::*;
;
	logic              clk_in = 1'b0;
	logic              sys_rst_in = 1'b1;
	logic [ADDR_W-1:0] addr_in = '0;
	logic [31:0]       wdata_in = '0;
	logic              wr_in = 1'b0;
	logic              rd_in = 1'b0;
	logic              mop = 1'b0;
	logic              rel = 1'b0;
	logic              busy_in = 1'b0;
	logic [7:0]        rx_shift_in = '0;
	logic [5:0]        pl = '0;
	logic [31:0]       rdata_out;
	logic [7:0]        tx_data_out;
	logic              scl, sda, on, load, irq_out;
	int                failures = 0;
	int                cmp_count = 0;
	int                cyc = 0;
	int                loads = 0;
	// 40 MHz block clock.
	always #12.5 clk_in = ~clk_in;
	isf_bus_model bm (.scl_out(scl), .sda_out(sda));
	isf_status dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .scl_in(scl), .sda_in(sda),
		.master_op_in(mop), .sda_release_in(rel), .tx_start_in(pl[0]), .gc_match_in(pl[1]),
		.ten_bit_addr_match_match_in(pl[2]), .slave_addr_match_in(pl[3]), .slave_byte_in(pl[4]),
		.rx_done_in(pl[5]), .rx_shift_in(rx_shift_in), .busy_in(busy_in), .module_on_out(on),
		.tx_load_out(load), .tx_data_out(tx_data_out), .irq_out(irq_out));
	function automatic logic [31:0] b(input int i);
		return 32'h1 << i;
	endfunction : b
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	// Strobes drop after their edge and a free cycle follows, so no signal is set twice at once.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask : wr
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 cmp($sformatf("reg %h", a), e, rdata_out);
		@(posedge clk_in);
	endtask : chk
	task automatic irq(input logic e);
		#1 cmp("irq", {31'h0, e}, {31'h0, irq_out});
		@(posedge clk_in);
	endtask : irq
	task automatic pulse(input int i);
		pl[i] <= 1'b1;
		@(posedge clk_in);
		pl <= '0;
		@(posedge clk_in);
	endtask : pulse
	// Pin edges need the synchroniser plus one cycle before flags move.
	task automatic lk();
		repeat (6) @(posedge clk_in);
	endtask : lk
	// Hang guard, far above the few hundred cycles the sequence needs; it also counts accepted bytes.
	always @(posedge clk_in) begin
		cyc++;
		if (load) begin
			loads++;
		end
		if (cyc == 8000) begin
			failures++;
			wrap_up();
		end
	end
	// Main sequence.
	initial begin
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		chk(OFS_STATUS, 32'h0);
		chk(8'h20, 32'h0);
		wr(OFS_CTRL, b(CTRL_ON_BIT));
		pulse(0);
		chk(OFS_STATUS, b(ST_TRS_BIT));
		bm.xfer(8'ha5, 1'b1);
		lk();
		chk(OFS_STATUS, b(ST_ACK_BIT));
		pulse(0);
		bm.xfer(8'h5a, 1'b0);
		lk();
		chk(OFS_STATUS, 32'h0);
		wr(OFS_EVT_EN, 32'h3f);
		irq(1'b1);
		wr(OFS_EVT_EN, 32'h0);
		irq(1'b0);
		wr(OFS_EVT_EN, 32'h3f);
		wr(OFS_EVT_CLR, 32'h3f);
		irq(1'b0);
		busy_in <= 1'b1;
		wr(OFS_TXBUF, 32'h3c);
		busy_in <= 1'b0;
		wr(OFS_TXBUF, 32'hc3);
		chk(OFS_TXBUF, 32'hc3);
		wr(OFS_STATUS, 32'hffff_ffff);
		chk(OFS_STATUS, b(ST_WCOL_BIT));
		rx_shift_in <= 8'h11;
		pulse(5);
		rx_shift_in <= 8'h22;
		pulse(5);
		chk(OFS_STATUS, b(ST_WCOL_BIT) | b(ST_OV_BIT));
		chk(OFS_RXBUF, 32'h11);
		wr(OFS_STATUS, 32'h0);
		pulse(5);
		chk(OFS_STATUS, 32'h0);
		pulse(1);
		pulse(2);
		pulse(4);
		chk(OFS_STATUS, b(ST_GC_BIT) | b(ST_A10_BIT) | b(ST_DA_BIT));
		pulse(3);
		bm.stop();
		lk();
		chk(OFS_STATUS, 32'h0);
		mop <= 1'b1;
		rel <= 1'b1;
		pulse(1);
		bm.slot(1'b0);
		bm.stop();
		lk();
		chk(OFS_STATUS, b(ST_BCL_BIT));
		mop <= 1'b0;
		wr(OFS_STATUS, 32'h0);
		pulse(1);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_TXBUF, 32'h77);
		cmp("tx_data", 32'hc3, {24'h0, tx_data_out});
		chk(OFS_STATUS, b(ST_BCL_BIT));
		wr(OFS_CTRL, b(CTRL_ON_BIT));
		chk(OFS_STATUS, 32'h0);
		cmp("on", 32'h1, {31'h0, on});
		cmp("loads", 32'h1, loads);
		wrap_up();
	end
endmodule : tb_i2c_status_flags
`default_nettype wire

// [hw/isf_status.sv]
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module isf_status
	import isf_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [31:0]       wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [31:0]       rdata_out,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	input  wire logic              master_op_in,
	input  wire logic              sda_release_in,
	input  wire logic              tx_start_in,
	input  wire logic              gc_match_in,
	input  wire logic              ten_bit_addr_match_match_in,
	input  wire logic              slave_addr_match_in,
	input  wire logic              slave_byte_in,
	input  wire logic              rx_done_in,
	input  wire logic [7:0]        rx_shift_in,
	input  wire logic              busy_in,
	output logic                   module_on_out,
	output logic                   tx_load_out,
	output logic      [7:0]        tx_data_out,
	output logic                   irq_out
);

	// ------------------------------------------------------------
	// Pin synchronisers and link edge detection
	// ------------------------------------------------------------
	logic scl_m_q;
	logic scl_s_q;
	logic scl_p_q;
	logic sda_m_q;
	logic sda_s_q;
	logic sda_p_q;

	// Three flops per pin; only the second and third stages feed any logic.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_in;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic stop_det;

	// A stop is data rising while the clock line stays high.
	assign scl_rise = scl_s_q & ~scl_p_q;
	assign scl_fall = ~scl_s_q & scl_p_q;
	assign stop_det = scl_s_q & scl_p_q & sda_s_q & ~sda_p_q;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	logic wr_status;
	logic wr_ctrl;
	logic wr_txbuf;
	logic rd_rxbuf;
	logic wr_evt_clr;
	logic wr_evt_en;

	assign wr_status  = wr_in && (addr_in == OFS_STATUS);
	assign wr_ctrl    = wr_in && (addr_in == OFS_CTRL);
	assign wr_txbuf   = wr_in && (addr_in == OFS_TXBUF);
	assign rd_rxbuf   = rd_in && (addr_in == OFS_RXBUF);
	assign wr_evt_clr = wr_in && (addr_in == OFS_EVT_CLR);
	assign wr_evt_en  = wr_in && (addr_in == OFS_EVT_EN);

	// ------------------------------------------------------------
	// Module enable
	// ------------------------------------------------------------
	logic on_q;
	logic re_enable;

	// Only an off-to-on write counts as re-enabling the module.
	assign re_enable = wr_ctrl && wdata_in[CTRL_ON_BIT] && !on_q;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			on_q <= 1'b0;
		end else if (wr_ctrl) begin
			on_q <= wdata_in[CTRL_ON_BIT];
		end
	end

	assign module_on_out = on_q;

	// ------------------------------------------------------------
	// Master transmit bit-slot tracking
	// ------------------------------------------------------------
	logic [3:0] slot_q;
	logic       ack_smp_q;
	logic       ack_end;
	logic       tx_act_q;

	// Counts clock rises from the start of a byte; the ninth is the
	// acknowledge, and the fall after it ends the slot.
	assign ack_end = on_q && scl_fall && (slot_q == ACK_SLOT);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !on_q) begin
			slot_q    <= 4'h0;
			ack_smp_q <= 1'b1;
		end else if (tx_start_in) begin
			slot_q <= 4'h0;
		end else if (ack_end) begin
			slot_q <= 4'h0;
		end else if (scl_rise && tx_act_q && slot_q != ACK_SLOT) begin
			slot_q <= slot_q + 4'h1;
			if (slot_q == ACK_SLOT - 4'h1) begin
				ack_smp_q <= sda_s_q;
			end
		end
	end

	// Collision: the master released data high but the line reads low.
	logic coll_det;

	assign coll_det = on_q && master_op_in && sda_release_in && scl_rise && !sda_s_q;

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	isf_flags_s flags;
	logic       ack_nr_q;
	logic       bcl_q;
	logic       gc_q;
	logic       a10_q;
	logic       wcol_q;
	logic       ov_q;
	logic       da_q;
	logic       rx_full_q;
	logic       ovf_det;
	logic       wcol_det;

	// Each flag has one register and one owner process; the carrier only gathers them.
	assign flags    = isf_flags_s'({ack_nr_q, tx_act_q, bcl_q, gc_q, a10_q, wcol_q, ov_q, da_q});
	assign ovf_det  = on_q && rx_done_in && rx_full_q;
	assign wcol_det = wr_txbuf && (busy_in || tx_act_q);

	// Hardware-only flags: status writes never reach them; software clears them only by writing the on bit to zero.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !on_q) begin
			ack_nr_q <= 1'b0;
			tx_act_q <= 1'b0;
			gc_q     <= 1'b0;
			a10_q    <= 1'b0;
			da_q     <= 1'b0;
		end else begin
			if (ack_end) begin
				ack_nr_q <= ack_smp_q;
			end
			if (tx_start_in) begin
				tx_act_q <= 1'b1;
			end else if (ack_end) begin
				tx_act_q <= 1'b0;
			end
			if (gc_match_in) begin
				gc_q <= 1'b1;
			end else if (stop_det) begin
				gc_q <= 1'b0;
			end
			if (ten_bit_addr_match_match_in) begin
				a10_q <= 1'b1;
			end else if (stop_det) begin
				a10_q <= 1'b0;
			end
			if (slave_byte_in) begin
				da_q <= 1'b1;
			end else if (slave_addr_match_in) begin
				da_q <= 1'b0;
			end
		end
	end

	// The collision flag survives a disable; it clears only when the
	// module is switched back on, and a fresh collision still wins.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			bcl_q <= 1'b0;
		end else if (coll_det) begin
			bcl_q <= 1'b1;
		end else if (re_enable) begin
			bcl_q <= 1'b0;
		end
	end

	// Software-cleared flags: a zero written clears, a new event wins.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !on_q) begin
			wcol_q <= 1'b0;
			ov_q   <= 1'b0;
		end else begin
			if (wcol_det) begin
				wcol_q <= 1'b1;
			end else if (wr_status && !wdata_in[ST_WCOL_BIT]) begin
				wcol_q <= 1'b0;
			end
			if (ovf_det) begin
				ov_q <= 1'b1;
			end else if (wr_status && !wdata_in[ST_OV_BIT]) begin
				ov_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit and receive buffers
	// ------------------------------------------------------------
	logic [7:0] rx_buf_q;

	// A full buffer is never overwritten: the old byte is kept and the
	// overflow flag tells software that the new one was lost.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !on_q) begin
			rx_buf_q  <= 8'h00;
			rx_full_q <= 1'b0;
		end else if (rx_done_in && !rx_full_q) begin
			rx_buf_q  <= rx_shift_in;
			rx_full_q <= 1'b1;
		end else if (rd_rxbuf) begin
			rx_full_q <= 1'b0;
		end
	end

	// A refused write leaves the held byte untouched and raises no load.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tx_data_out <= 8'h00;
			tx_load_out <= 1'b0;
		end else begin
			tx_load_out <= 1'b0;
			if (wr_txbuf && on_q && !wcol_det) begin
				tx_data_out <= wdata_in[7:0];
				tx_load_out <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt events
	// ------------------------------------------------------------
	logic [EVT_W-1:0] evt_q;
	logic [EVT_W-1:0] evt_en_q;
	logic [EVT_W-1:0] evt_set;

	always_comb begin
		evt_set          = '0;
		evt_set[EV_ACK]  = ack_end;
		evt_set[EV_BCL]  = coll_det;
		evt_set[EV_GC]   = on_q && gc_match_in;
		evt_set[EV_WCOL] = on_q && wcol_det;
		evt_set[EV_OV]   = ovf_det;
		evt_set[EV_STOP] = on_q && stop_det;
	end

	// Sticky bits; a set in the same cycle as its clear is kept.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			evt_q <= '0;
		end else if (wr_evt_clr) begin
			evt_q <= (evt_q & ~wdata_in[EVT_W-1:0]) | evt_set;
		end else begin
			evt_q <= evt_q | evt_set;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			evt_en_q <= '0;
		end else if (wr_evt_en) begin
			evt_en_q <= wdata_in[EVT_W-1:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(evt_q & evt_en_q);
		end
	end

	// ------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rdata_out <= RST_WORD;
		end else if (rd_in) begin
			case (addr_in)
				OFS_STATUS: rdata_out <= isf_status_word(flags);
				OFS_CTRL:   rdata_out <= {16'h0000, on_q, 15'h0000};
				OFS_TXBUF:  rdata_out <= {24'h000000, tx_data_out};
				OFS_RXBUF:  rdata_out <= {24'h000000, rx_buf_q};
				OFS_EVT:    rdata_out <= {{(32-EVT_W){1'b0}}, evt_q};
				OFS_EVT_EN: rdata_out <= {{(32-EVT_W){1'b0}}, evt_en_q};
				default:    rdata_out <= RST_WORD;
			endcase
		end else begin
			rdata_out <= RST_WORD;
		end
	end

endmodule : isf_status
`default_nettype wire

// [include/isf_pkg.sv]
`default_nettype none
package isf_pkg;

	// ------------------------------------------------------------
	// Register map, byte addresses of 32-bit words
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  OFS_STATUS  = 8'h00;
	localparam logic [7:0]  OFS_CTRL    = 8'h04;
	localparam logic [7:0]  OFS_TXBUF   = 8'h08;
	localparam logic [7:0]  OFS_RXBUF   = 8'h0c;
	localparam logic [7:0]  OFS_EVT     = 8'h10;
	localparam logic [7:0]  OFS_EVT_CLR = 8'h14;
	localparam logic [7:0]  OFS_EVT_EN  = 8'h18;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_ON_BIT = 15;
	localparam int unsigned ST_ACK_BIT  = 15;
	localparam int unsigned ST_TRS_BIT  = 14;
	localparam int unsigned ST_BCL_BIT  = 10;
	localparam int unsigned ST_GC_BIT   = 9;
	localparam int unsigned ST_A10_BIT  = 8;
	localparam int unsigned ST_WCOL_BIT = 7;
	localparam int unsigned ST_OV_BIT   = 6;
	localparam int unsigned ST_DA_BIT   = 5;

	// Event bits of the interrupt status, clear and enable registers.
	localparam int unsigned EVT_W       = 6;
	localparam int unsigned EV_ACK      = 0;
	localparam int unsigned EV_BCL      = 1;
	localparam int unsigned EV_GC       = 2;
	localparam int unsigned EV_WCOL     = 3;
	localparam int unsigned EV_OV       = 4;
	localparam int unsigned EV_STOP     = 5;

	// Bit slots of one transmitted byte: eight data bits plus acknowledge.
	localparam logic [3:0]  ACK_SLOT    = 4'h9;
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;

	// ------------------------------------------------------------
	// Status flag carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic ack_not_received;
		logic master_tx_active;
		logic bus_collision_flag;
		logic general_call_hit;
		logic ten_bit_addr_match;
		logic tx_write_collision;
		logic rx_overflow_flag;
		logic data_not_address;
	} isf_flags_s;

	localparam isf_flags_s FLAGS_RST = '0;

	// Places the flags at their status word positions, all else zero.
	function automatic logic [31:0] isf_status_word(input isf_flags_s f);
		logic [31:0] w;
		w = RST_WORD;
		w[ST_ACK_BIT]  = f.ack_not_received;
		w[ST_TRS_BIT]  = f.master_tx_active;
		w[ST_BCL_BIT]  = f.bus_collision_flag;
		w[ST_GC_BIT]   = f.general_call_hit;
		w[ST_A10_BIT]  = f.ten_bit_addr_match;
		w[ST_WCOL_BIT] = f.tx_write_collision;
		w[ST_OV_BIT]   = f.rx_overflow_flag;
		w[ST_DA_BIT]   = f.data_not_address;
		return w;
	endfunction : isf_status_word

endpackage : isf_pkg
`default_nettype wire
